// File: design/sar_adc_serial_control.sv
// Serial control byte, conversion sequencing and result readout
module sar_adc_serial_control (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        serial_shift_clock,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic        cmp_above,
  output logic             busy,
  output logic             busy_oe,
  output logic             sdo,
  output logic             sdo_oe,
  output logic [2:0]       channel_select_code,
  output logic             input_mode_select,
  output logic [1:0]       power_mode_select,
  output logic             low_power,
  output logic             acquire,
  output logic             hold,
  output logic [15:0]      ext_trial_code,
  output logic [15:0]      int_trial_code
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // One successive-approximation step on bit idx
  function automatic logic [15:0] sar_step(input logic [15:0] code,
                                           input logic [3:0]  idx,
                                           input logic        above);
    logic [15:0] nxt;
    nxt      = code;
    nxt[idx] = above;
    if (idx != 4'h0) begin
      nxt[idx - 4'h1] = 1'b1;
    end
    return nxt;
  endfunction : sar_step

  // ------------------------------------------------------------------
  // Link domain: control byte shift-in
  // ------------------------------------------------------------------
  logic        link_clr;
  logic        in_frame_r;
  logic [2:0]  bit_cnt_r;
  logic [5:0]  shift_r;
  logic [7:0]  ctrl_byte_r;
  logic        ctrl_tog_r;
  logic        acq_r;
  logic        conv_act_r;
  logic        conv_run_r;
  logic [4:0]  phase_r;
  logic        busy_ext_r;
  logic        sdo_ext_r;
  logic        byte_done;
  logic        start_ok;
  logic [7:0]  ctrl_nxt;

  // Select high parks the link side except the byte register and event toggle
  assign link_clr  = cs_n | rst;
  assign byte_done = in_frame_r && (bit_cnt_r == sar_adc_serial_control_pkg::CNT_LAST);
  assign ctrl_nxt  = {1'b1, shift_r, sdi};
  assign start_ok  = !conv_act_r
                     || (phase_r >= sar_adc_serial_control_pkg::PH_LSB);

  always_ff @(posedge serial_shift_clock or posedge link_clr) begin
    if (link_clr) begin
      in_frame_r <= 1'b0;
      bit_cnt_r  <= 3'h0;
      shift_r    <= 6'h00;
    end else if (!in_frame_r) begin
      if (sdi && start_ok) begin
        in_frame_r <= 1'b1;
        bit_cnt_r  <= 3'h0;
      end
    end else begin
      shift_r   <= {shift_r[4:0], sdi};
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        in_frame_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge serial_shift_clock or posedge rst) begin
    if (rst) begin
      ctrl_byte_r <= sar_adc_serial_control_pkg::CTRL_RST;
    end else if (byte_done) begin
      ctrl_byte_r <= ctrl_nxt;
    end
  end

  // Event toggle survives select, so a finished byte is never lost
  always_ff @(posedge serial_shift_clock or posedge rst) begin
    if (rst) begin
      ctrl_tog_r <= 1'b0;
    end else if (byte_done) begin
      ctrl_tog_r <= ~ctrl_tog_r;
    end
  end

  always_ff @(posedge serial_shift_clock or posedge link_clr) begin
    if (link_clr) begin
      acq_r <= 1'b0;
    end else if (byte_done) begin
      acq_r <= 1'b0;
    end else if (in_frame_r && bit_cnt_r == sar_adc_serial_control_pkg::CNT_ACQ) begin
      acq_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: external clock conversion
  // ------------------------------------------------------------------
  always_ff @(posedge serial_shift_clock or posedge link_clr) begin
    if (link_clr) begin
      conv_act_r     <= 1'b0;
      conv_run_r     <= 1'b0;
      phase_r        <= sar_adc_serial_control_pkg::PH_BUSY;
      ext_trial_code <= sar_adc_serial_control_pkg::CODE_RST;
    end else if (byte_done) begin
      conv_act_r     <= ctrl_nxt[1:0] != sar_adc_serial_control_pkg::PD_INTCLK;
      conv_run_r     <= ctrl_nxt[1:0] != sar_adc_serial_control_pkg::PD_INTCLK;
      phase_r        <= sar_adc_serial_control_pkg::PH_BUSY;
      ext_trial_code <= sar_adc_serial_control_pkg::TRIAL_INIT;
    end else if (conv_act_r && phase_r != sar_adc_serial_control_pkg::PH_ZERO) begin
      phase_r <= phase_r + 5'h01;
      if (phase_r <= sar_adc_serial_control_pkg::PH_LAST_DEC) begin
        ext_trial_code <= sar_step(ext_trial_code, 4'(~phase_r[3:0]),
                                   cmp_above);
      end
      if (phase_r == sar_adc_serial_control_pkg::PH_LAST_DEC) begin
        conv_run_r <= 1'b0;
      end
    end
  end

  // Busy and result bits change on falling edges
  always_ff @(negedge serial_shift_clock or posedge link_clr) begin
    if (link_clr) begin
      busy_ext_r <= 1'b0;
      sdo_ext_r  <= 1'b0;
    end else begin
      busy_ext_r <= conv_act_r
                    && phase_r == sar_adc_serial_control_pkg::PH_BUSY;
      if (conv_act_r && phase_r != sar_adc_serial_control_pkg::PH_BUSY
          && phase_r <= sar_adc_serial_control_pkg::PH_LSB) begin
        sdo_ext_r <= ext_trial_code[4'(sar_adc_serial_control_pkg::PH_LSB
                                       - phase_r)];
      end else begin
        sdo_ext_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Core domain: synchronisers
  // ------------------------------------------------------------------
  logic       sclk_s1, sclk_s2, sclk_s3;
  logic       cs_s1, cs_s2;
  logic       tog_s1, tog_s2, tog_s3;
  logic       bsy_s1, bsy_s2;
  logic       dat_s1, dat_s2;
  logic       run_s1, run_s2, run_s3;
  logic       acq_s1, acq_s2;
  logic       new_ctrl;
  logic       sclk_fall;
  logic       int_mode;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2}              <= 2'h3;
      {tog_s1, tog_s2, tog_s3}    <= 3'h0;
      {bsy_s1, bsy_s2}            <= 2'h0;
      {dat_s1, dat_s2}            <= 2'h0;
      {run_s1, run_s2, run_s3}    <= 3'h0;
      {acq_s1, acq_s2}            <= 2'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_shift_clock, sclk_s1, sclk_s2};
      {cs_s1, cs_s2}              <= {cs_n, cs_s1};
      {tog_s1, tog_s2, tog_s3}    <= {ctrl_tog_r, tog_s1, tog_s2};
      {bsy_s1, bsy_s2}            <= {busy_ext_r, bsy_s1};
      {dat_s1, dat_s2}            <= {sdo_ext_r, dat_s1};
      {run_s1, run_s2, run_s3}    <= {conv_run_r, run_s1, run_s2};
      {acq_s1, acq_s2}            <= {acq_r, acq_s1};
    end
  end

  assign new_ctrl  = tog_s2 ^ tog_s3;
  assign sclk_fall = sclk_s3 & ~sclk_s2;
  assign int_mode  = power_mode_select == sar_adc_serial_control_pkg::PD_INTCLK;

  // ------------------------------------------------------------------
  // Core domain: control fields
  // ------------------------------------------------------------------
  // Byte register survives select and stays stable after its toggle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_select_code <= 3'h0;
      input_mode_select   <= 1'b0;
      power_mode_select   <= sar_adc_serial_control_pkg::PD_AUTO;
    end else if (new_ctrl) begin
      channel_select_code <= ctrl_byte_r[sar_adc_serial_control_pkg::CHAN_HI:
                                         sar_adc_serial_control_pkg::CHAN_LO];
      // High: against common input, low: differential pair
      input_mode_select   <= ctrl_byte_r[sar_adc_serial_control_pkg::MODE_BIT];
      power_mode_select   <= ctrl_byte_r[sar_adc_serial_control_pkg::PD_HI:
                                         sar_adc_serial_control_pkg::PD_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_power <= 1'b0;
    end else if (new_ctrl || (run_s2 && !run_s3)) begin
      low_power <= 1'b0;
    end else if (!run_s2 && run_s3
                 && power_mode_select == sar_adc_serial_control_pkg::PD_AUTO) begin
      low_power <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Core domain: internal clock conversion and readout
  // ------------------------------------------------------------------
  sar_adc_serial_control_pkg::int_state_t state_r;
  logic [5:0] step_cnt_r;
  logic [3:0] int_bit_r;
  logic [4:0] rd_cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r        <= sar_adc_serial_control_pkg::IST_IDLE;
      step_cnt_r     <= 6'h00;
      int_bit_r      <= 4'h0;
      int_trial_code <= sar_adc_serial_control_pkg::CODE_RST;
    end else if (new_ctrl) begin
      if (ctrl_byte_r[1:0] == sar_adc_serial_control_pkg::PD_INTCLK) begin
        state_r        <= sar_adc_serial_control_pkg::IST_CONV;
        step_cnt_r     <= sar_adc_serial_control_pkg::STEP_LOAD;
        int_bit_r      <= 4'hf;
        int_trial_code <= sar_adc_serial_control_pkg::TRIAL_INIT;
      end else begin
        state_r <= sar_adc_serial_control_pkg::IST_IDLE;
      end
    end else begin
      case (state_r)
        sar_adc_serial_control_pkg::IST_CONV: begin
          // Select only picks wait or readout after the last bit, so raising it is harmless
          if (step_cnt_r != 6'h00) begin
            step_cnt_r <= step_cnt_r - 6'h01;
          end else begin
            step_cnt_r     <= sar_adc_serial_control_pkg::STEP_LOAD;
            int_trial_code <= sar_step(int_trial_code, int_bit_r, cmp_above);
            int_bit_r      <= int_bit_r - 4'h1;
            if (int_bit_r == 4'h0) begin
              state_r <= cs_s2 ? sar_adc_serial_control_pkg::IST_WAIT
                               : sar_adc_serial_control_pkg::IST_READ;
            end
          end
        end
        sar_adc_serial_control_pkg::IST_WAIT: begin
          if (!cs_s2) begin
            state_r <= sar_adc_serial_control_pkg::IST_READ;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || new_ctrl || state_r != sar_adc_serial_control_pkg::IST_READ) begin
      rd_cnt_r <= 5'h00;
    end else if (sclk_fall && !cs_s2 && rd_cnt_r != sar_adc_serial_control_pkg::PH_ZERO) begin
      rd_cnt_r <= rd_cnt_r + 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // Core domain: pins and analog controls
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy    <= 1'b0;
      busy_oe <= 1'b0;
    end else if (int_mode) begin
      busy    <= state_r != sar_adc_serial_control_pkg::IST_CONV;
      busy_oe <= 1'b1;
    end else begin
      busy    <= bsy_s2;
      busy_oe <= !cs_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (int_mode) begin
      sdo_oe <= !cs_s2 && state_r == sar_adc_serial_control_pkg::IST_READ;
      if (state_r != sar_adc_serial_control_pkg::IST_READ) begin
        sdo <= 1'b0;
      end else if (sclk_fall && !cs_s2) begin
        sdo <= rd_cnt_r < sar_adc_serial_control_pkg::PH_LSB
               ? int_trial_code[4'(~rd_cnt_r[3:0])] : 1'b0;
      end
    end else begin
      sdo    <= dat_s2;
      sdo_oe <= !cs_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acquire <= 1'b0;
      hold    <= 1'b0;
    end else begin
      acquire <= acq_s2;
      hold    <= run_s2 || state_r == sar_adc_serial_control_pkg::IST_CONV
                 || (new_ctrl && ctrl_byte_r[1:0]
                     == sar_adc_serial_control_pkg::PD_INTCLK);
    end
  end

endmodule : sar_adc_serial_control

// File: design/sar_adc_serial_control_pkg.sv
// Constants and types shared by the serial converter control logic
package sar_adc_serial_control_pkg;

  // ------------------------------------------------------------------
  // Control byte layout
  // ------------------------------------------------------------------
  localparam int          CTRL_W        = 8;
  localparam int          START_BIT     = 7;
  localparam int          CHAN_HI       = 6;
  localparam int          CHAN_LO       = 4;
  localparam int          MODE_BIT      = 2;
  localparam int          PD_HI         = 1;
  localparam int          PD_LO         = 0;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  // ------------------------------------------------------------------
  // Power mode codes
  // ------------------------------------------------------------------
  localparam logic [1:0]  PD_AUTO       = 2'h0;
  localparam logic [1:0]  PD_INTCLK     = 2'h1;
  localparam logic [1:0]  PD_RSVD       = 2'h2;
  localparam logic [1:0]  PD_FULL       = 2'h3;

  // ------------------------------------------------------------------
  // Serial sequence counts
  // ------------------------------------------------------------------
  localparam int          RES_W         = 16;
  localparam logic [2:0]  CNT_ACQ       = 3'h3;  // 5th bit of the byte
  localparam logic [2:0]  CNT_LAST      = 3'h6;  // 8th bit of the byte
  localparam logic [4:0]  PH_BUSY       = 5'h00;
  localparam logic [4:0]  PH_LSB        = 5'h10;
  localparam logic [4:0]  PH_LAST_DEC   = 5'h0f;
  localparam logic [4:0]  PH_ZERO       = 5'h11;
  localparam logic [15:0] TRIAL_INIT    = 16'h8000;
  localparam logic [15:0] CODE_RST      = 16'h0000;

  // ------------------------------------------------------------------
  // Internal conversion timing
  // ------------------------------------------------------------------
  localparam int          CORE_PERIOD_NS = 10;
  localparam int          BUSY_MAX_NS    = 8000;
  localparam int          INT_CONV_CYC   = BUSY_MAX_NS / CORE_PERIOD_NS;
  localparam int          INT_STEP_CYC   = INT_CONV_CYC / RES_W;
  localparam logic [5:0]  STEP_LOAD      = 6'(INT_STEP_CYC - 1);

  // ------------------------------------------------------------------
  // Internal clock mode sequencer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    IST_IDLE = 2'h0,
    IST_CONV = 2'h1,
    IST_READ = 2'h3,
    IST_WAIT = 2'h2
  } int_state_t;

endpackage : sar_adc_serial_control_pkg

// File: verif/host_serial_port.sv
// Host serial port model: select, serial clock and control bits
module host_serial_port (
  output logic      serial_shift_clock,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_pin,
  input  wire logic busy_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serial_shift_clock = 1'b0;
    cs_n               = 1'b1;
    sdi                = 1'b0;
  end

  task automatic set_cs(input logic v);
    cs_n = v;
  endtask : set_cs

  // Clock runs only inside frames and rests low between them
  task automatic xfer(input logic [63:0] din, input int n, input int half,
                      input logic [63:0] gap, output logic [63:0] so,
                      output logic [63:0] bo);
    so = '0;
    bo = '0;
    #1.3;
    cs_n = 1'b0;
    #(half);
    for (int i = 1; i <= n; i++) begin
      sdi = din[i];
      #(half);
      serial_shift_clock = 1'b1;
      so[i] = sdo_pin;
      bo[i] = busy_pin;
      #(half);
      serial_shift_clock = 1'b0;
      if (gap[i]) #1700;
    end
  endtask : xfer
endmodule : host_serial_port

// File: verif/sar_adc_serial_control_properties.sv
// Port-level checks for the serial converter control block
module sar_adc_serial_control_properties (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       serial_shift_clock,
  input wire logic       cs_n,
  input wire logic       busy,
  input wire logic       busy_oe,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic [1:0] power_mode_select,
  input wire logic       low_power,
  input wire logic       acquire,
  input wire logic       hold
);
  logic       clk_q_r;
  logic [3:0] fall_age_r;
  wire        int_mode = power_mode_select ==
                         sar_adc_serial_control_pkg::PD_INTCLK;

  // Core cycles since the last serial clock fall, saturating
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_q_r    <= 1'b0;
      fall_age_r <= 4'hf;
    end else begin
      clk_q_r <= serial_shift_clock;
      if (clk_q_r && !serial_shift_clock) fall_age_r <= 4'h0;
      else if (fall_age_r != 4'hf) fall_age_r <= fall_age_r + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_cs_idle;
    cs_n [*4];
  endsequence
  sequence s_busy_pulse;
    busy [*2] ##[1:4] !busy;
  endsequence

  a_sdo_float_cs: assert property (s_cs_idle |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_busy_float_ext: assert property (
    (cs_n && !int_mode) [*4] |-> !busy_oe)
    else $error("busy driven while deselected");
  a_busy_kept_int: assert property (
    (cs_n && int_mode) [*4] |-> busy_oe)
    else $error("busy released in internal mode");
  a_busy_low_select: assert property (
    $fell(cs_n) && !int_mode |-> ##[1:5] (busy_oe && !busy))
    else $error("busy not driven low after select");
  a_busy_one_clock: assert property (
    $rose(busy) && !int_mode |-> s_busy_pulse)
    else $error("busy pulse length wrong");
  a_busy_after_fall: assert property (
    $rose(busy) && !int_mode |-> fall_age_r <= 4'h6)
    else $error("busy rose away from a clock fall");
  a_int_busy_bound: assert property (
    $fell(busy) && int_mode |-> ##[1:800] busy)
    else $error("internal conversion too long");
  a_hold_after_acq: assert property ($rose(hold) |-> $past(acquire))
    else $error("hold without acquisition");
  a_low_power_auto: assert property (
    low_power |-> power_mode_select == sar_adc_serial_control_pkg::PD_AUTO)
    else $error("low power outside auto mode");
  a_wake_on_start: assert property ($rose(hold) |-> ##1 !low_power)
    else $error("still low power during conversion");
  a_sdo_on_fall: assert property (
    $changed(sdo) && sdo_oe && $past(sdo_oe) |-> fall_age_r <= 4'h6)
    else $error("data out changed away from a clock fall");
endmodule : sar_adc_serial_control_properties

bind sar_adc_serial_control sar_adc_serial_control_properties i_props (
  .core_clk(core_clk), .rst(rst), .serial_shift_clock(serial_shift_clock),
  .cs_n(cs_n), .busy(busy), .busy_oe(busy_oe), .sdo(sdo), .sdo_oe(sdo_oe),
  .power_mode_select(power_mode_select), .low_power(low_power),
  .acquire(acquire), .hold(hold));

// File: verif/tb_top.sv
// Self-checking bench for the serial converter control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmp_above = 1'b0;
  wire         serial_shift_clock, cs_n, sdi;
  logic        busy, busy_oe, sdo, sdo_oe, input_mode_select;
  logic        low_power, acquire, hold;
  logic [2:0]  channel_select_code;
  logic [1:0]  power_mode_select;
  logic [15:0] ext_trial_code, int_trial_code;
  logic [15:0] target = 16'h0000;
  wire         sdo_pin = sdo_oe ? sdo : 1'bz;
  wire         busy_pin = busy_oe ? busy : 1'bz;
  int          bad_count = 0;
  int          tests_run = 0;

  always #5 core_clk = ~core_clk;

  // Comparator stand-in: input level is target
  always @(negedge core_clk)
    cmp_above <= target >= (power_mode_select ==
      sar_adc_serial_control_pkg::PD_INTCLK ? int_trial_code : ext_trial_code);

  sar_adc_serial_control i_sar_adc_serial_control (
    .core_clk(core_clk), .rst(rst), .serial_shift_clock(serial_shift_clock),
    .cs_n(cs_n), .sdi(sdi), .cmp_above(cmp_above), .busy(busy),
    .busy_oe(busy_oe), .sdo(sdo), .sdo_oe(sdo_oe),
    .channel_select_code(channel_select_code),
    .input_mode_select(input_mode_select),
    .power_mode_select(power_mode_select), .low_power(low_power),
    .acquire(acquire), .hold(hold), .ext_trial_code(ext_trial_code),
    .int_trial_code(int_trial_code));

  host_serial_port i_host_serial_port (
    .serial_shift_clock(serial_shift_clock), .cs_n(cs_n), .sdi(sdi),
    .sdo_pin(sdo_pin), .busy_pin(busy_pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [63:0] put(input logic [7:0] b, input int p);
    put = '0;
    for (int j = 0; j < 8; j++) put[p + j] = b[7 - j];
  endfunction : put

  task automatic t_ext_overlap;
    logic [63:0] so, bo;
    target = 16'hb3c5;
    i_host_serial_port.xfer(put(8'hd3, 3) | put(8'ha4, 27), 60, 16,
                            (64'h1 << 7) | (64'h1 << 31), so, bo);
    for (int k = 0; k < 23; k++) begin
      if (k < 16) chk(so[13 + k], target[15 - k]);
      chk(so[37 + k], k < 16 ? target[15 - k] : 1'b0);
    end
    for (int c = 0; c < 48; c += 24) chk(bo[12 + c +: 2], 2'b01);
    chk({channel_select_code, input_mode_select, power_mode_select},
        6'b010100);
    chk(low_power, 1'b1);
    $display("external overlap test done");
  endtask : t_ext_overlap

  task automatic t_ext_cs;
    logic [63:0] so, bo;
    i_host_serial_port.set_cs(1'b1);
    repeat (4) @(negedge core_clk);
    chk({busy_pin, sdo_pin}, 2'bzz);
    i_host_serial_port.set_cs(1'b0);
    repeat (6) @(negedge core_clk);
    chk({busy_oe, busy}, 2'b10);
    target = 16'h0001;
    i_host_serial_port.xfer(put(8'h9b, 1), 34, 16, 64'h1 << 5, so, bo);
    for (int k = 0; k < 23; k++)
      chk(so[11 + k], k < 16 ? target[15 - k] : 1'b0);
    chk({channel_select_code, input_mode_select, power_mode_select},
        6'b001011);
    chk(low_power, 1'b0);
    chk(ext_trial_code, target);
    $display("external select test done");
  endtask : t_ext_cs

  task automatic t_int(input logic hi, input logic [15:0] v);
    logic [63:0] so, bo;
    int n;
    target = v;
    i_host_serial_port.xfer(put(8'he5, 1), 8, 16, 64'h1 << 5, so, bo);
    i_host_serial_port.set_cs(hi);
    repeat (10) @(negedge core_clk);
    chk({busy_oe, busy}, 2'b10);
    chk({acquire, hold}, 2'b01);
    n = 10;
    while (busy === 1'b0 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n > 790 && n <= 805, 1'b1);
    repeat (5) @(negedge core_clk);
    chk(sdo_oe, !hi);
    chk(int_trial_code, v);
    if (hi) begin
      i_host_serial_port.set_cs(1'b0);
      repeat (5) @(negedge core_clk);
      chk(sdo_oe, 1'b1);
    end
    i_host_serial_port.xfer(64'h0, 18, 250, 64'h0, so, bo);
    for (int k = 0; k < 17; k++)
      chk(so[2 + k], k < 16 ? v[15 - k] : 1'b0);
    chk({channel_select_code, input_mode_select, power_mode_select},
        6'b110101);
    $display("internal clock test done");
  endtask : t_int

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_ext_overlap();
    t_ext_cs();
    t_int(1'b0, 16'h6a1f);
    t_int(1'b1, 16'h8000);
    end_of_test();
  end
endmodule : tb_top
